// >>> rtl/fbc_cfg.svh
// Constants for the flag branch, call and timer execution block
`ifndef FBC_CFG_SVH
`define FBC_CFG_SVH
`define FBC_OP_JF_P0 10'h1D1
`define FBC_OP_JF_P1 10'h211
`define FBC_OP_JNF_P0 10'h1F1
`define FBC_OP_JNF_P1 10'h231
`define FBC_OP_CALL 10'h0D2
`define FBC_OP_RET 10'h112
`define FBC_OP_RDT0 10'h3DF
`define FBC_OP_RDT1 10'h3FF
`define FBC_OP_WRT0 10'h09F
`define FBC_OP_WRT1 10'h0BF
`define FBC_OP_LDTI 10'h0DF
`define FBC_OP_LDTM 10'h0FF
`define FBC_OP_HALT 10'h051
`define FBC_OP_STTSI 10'h071
`define FBC_OP_STTSR_HI 5'h01
`define FBC_OP_CARRY_ON_ALL_ONES 10'h353
`define FBC_PAGE_BITS 1
`define FBC_RESET_PC 11'h000
`define FBC_TMR_SLOW 64
`define FBC_TMR_FAST 128
`endif

// >>> rtl/fbc_exec.sv
// Execution logic for flag branch, call, timer, standby and status tests
// How it works
// - Jump-if-flag loads target when flag set, else PC plus two
// - Jump-if-flag-clear loads target when flag clear, else skips both words
// - Program memory in 1K pages; large variant pages 0 and 1, small page 0
// - Call takes two cycles: bump stack pointer, save PC, load target
// - Stack pointer carry on call raises internal reset
// - Return takes one cycle: restore PC, then drop stack pointer
// - Stack pointer borrow on return raises internal reset
// - Timer nibble read gives bits 9:6 or 5:2 and clears carry
// - Timer nibble write loads 9:6 clearing bit 1, or 5:2 clearing bit 0
// - Load-timer-immediate puts ten immediate bits into the timer
// - Timer interval is value plus one times 64 or 128 clocks
// - Load-timer-from-memory reads word at page control plus pointer pair
// - Standby instruction enters standby; immediate picks release condition
// - Register status test sets flag on any enabled status match
// - Immediate status test matches the same way, sets or clears flag
// - Carry-on-all-ones sets carry only when accumulator is all ones
// - False branch advances PC by two, skipping the target word
`include "fbc_cfg.svh"
module fbc_exec
  import fbc_pkg::*;
#(
  parameter int TMR_DIV = `FBC_TMR_SLOW,
  parameter bit BIG_ROM = 1'b1
) (
  input wire logic mclk,
  input wire logic arst_n,
  input wire logic [9:0] rom_data,
  output logic [10:0] rom_addr,
  input wire logic [3:0] accum_in,
  input wire logic [3:0] low_bank_register,
  input wire logic [2:0] rom_page_control,
  input wire logic [7:0] rom_pointer_pair,
  input wire logic sense_input_a,
  input wire logic sense_input_b,
  input wire logic [7:0] key_io_lines,
  input wire logic [3:0] key_input_lines,
  input wire logic wake,
  output logic [3:0] accum_out,
  output logic accum_we,
  output logic carry_flag,
  output logic test_flag,
  output logic [9:0] timer_value,
  output logic timer_status,
  output logic standby,
  output logic [3:0] standby_cond,
  output logic internal_reset
);
  logic rst_a, rst_n;
  logic sa1, sa2, sb1, sb2, ko2, ki2, wk1, wk2;
  logic [7:0] kio1;
  logic [3:0] kin1;
  fbc_state_type state;
  fbc_kind_type kind;
  logic [10:0] pc, address_stack_reg;
  logic sp;
  logic [9:0] tcount;
  logic [7:0] tdiv;
  logic ldtm_pend;
  logic [3:0] status_test_reg;
  // Page of the pending branch or call target
  logic opg;

  // Operand word to target address
  function automatic logic [9:0] op_target(input logic [9:0] w);
    return {w[9], w[4], w[8:5], w[3:0]};
  endfunction

  // Reset release
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      rst_a <= 1'b0;
      rst_n <= 1'b0;
    end else begin
      rst_a <= 1'b1;
      rst_n <= rst_a;
    end
  end

  // Pin synchronisers
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      sa1 <= 1'b0; sa2 <= 1'b0; sb1 <= 1'b0; sb2 <= 1'b0;
      kio1 <= 8'h00; ko2 <= 1'b0; kin1 <= 4'h0; ki2 <= 1'b0;
      wk1 <= 1'b0; wk2 <= 1'b0;
    end else begin
      sa1 <= sense_input_a; sa2 <= sa1;
      sb1 <= sense_input_b; sb2 <= sb1;
      kio1 <= key_io_lines; ko2 <= |kio1;
      kin1 <= key_input_lines; ki2 <= |kin1;
      wk1 <= wake; wk2 <= wk1;
    end
  end

  wire [9:0] ir = rom_data;
  // Target address bit order on the operand word
  wire [9:0] target = op_target(ir);
  // Page 1 opcodes only exist on the large variant
  wire is_jf1 = BIG_ROM && (ir == `FBC_OP_JF_P1);
  wire is_jnf1 = BIG_ROM && (ir == `FBC_OP_JNF_P1);
  wire is_jf = (ir == `FBC_OP_JF_P0) || is_jf1;
  wire is_jnf = (ir == `FBC_OP_JNF_P0) || is_jnf1;
  wire is_call = (ir == `FBC_OP_CALL);
  wire is_ret = (ir == `FBC_OP_RET);
  wire is_rdt = (ir == `FBC_OP_RDT0) || (ir == `FBC_OP_RDT1);
  wire is_wt0 = (ir == `FBC_OP_WRT0);
  wire is_wt1 = (ir == `FBC_OP_WRT1);
  wire is_ldti = (ir == `FBC_OP_LDTI);
  wire is_ldtm = (ir == `FBC_OP_LDTM);
  wire is_halt = (ir == `FBC_OP_HALT);
  wire is_sttsi = (ir == `FBC_OP_STTSI);
  wire is_sttsr = (ir[9:5] == `FBC_OP_STTSR_HI) && (ir[4] == 1'b0);
  wire is_carry_on_all_ones = (ir == `FBC_OP_CARRY_ON_ALL_ONES);
  wire [3:0] status_vec = {timer_status, ki2, ko2, sa2 | sb2};
  wire status_test_match = |(status_vec & status_test_reg);
  wire tick = (tdiv == 8'(TMR_DIV - 1));
  // Expiry beats a status-test clear in the same cycle
  wire tmr_expire = tick && (tcount == 10'h000);
  wire [10:0] pc_next1 = pc + 11'h001;
  wire [10:0] pc_next2 = pc + 11'h002;
  wire [10:0] page_mask = BIG_ROM ? 11'h7FF : 11'h3FF;
  wire stack_fault = (state == FBC_FETCH) && !ldtm_pend &&
                     ((is_call && sp) || (is_ret && !sp));

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      state <= FBC_FETCH;
      kind <= FBC_K_NONE;
      pc <= `FBC_RESET_PC;
      address_stack_reg <= 11'h000;
      sp <= 1'b0;
      rom_addr <= 11'h000;
      accum_out <= 4'h0;
      accum_we <= 1'b0;
      carry_flag <= 1'b0;
      test_flag <= 1'b0;
      timer_value <= 10'h000;
      tcount <= 10'h000;
      tdiv <= 8'h00;
      timer_status <= 1'b0;
      standby <= 1'b0;
      standby_cond <= 4'h0;
      internal_reset <= 1'b0;
      ldtm_pend <= 1'b0;
      status_test_reg <= 4'h0;
      opg <= 1'b0;
    end else begin
      accum_we <= 1'b0;
      internal_reset <= 1'b0;
      // Timer: interval (value+1) x divider clocks
      tdiv <= tick ? 8'h00 : tdiv + 8'h01;
      if (tick) begin
        if (tcount == 10'h000) begin
          tcount <= timer_value;
          timer_status <= 1'b1;
        end else begin
          tcount <= tcount - 10'h001;
        end
      end
      if (stack_fault) begin
        // Stack over/underflow restarts as reset
        internal_reset <= 1'b1;
        pc <= `FBC_RESET_PC;
        sp <= 1'b0;
        rom_addr <= `FBC_RESET_PC;
        state <= FBC_FETCH;
      end else if (ldtm_pend) begin
        // Table word into timer
        timer_value <= rom_data;
        ldtm_pend <= 1'b0;
        rom_addr <= pc;
      end else begin
        unique case (state)
          FBC_FETCH: begin
            rom_addr <= pc_next1 & page_mask;
            pc <= pc_next1 & page_mask;
            if (is_jf || is_jnf || is_call || is_ldti || is_halt ||
                is_sttsi) begin
              state <= FBC_OPND;
              // Call stays in its own page
              opg <= is_call ? pc[10] : (is_jf1 || is_jnf1);
              kind <= is_jf ? FBC_K_JF : is_jnf ? FBC_K_JNF :
                      is_call ? FBC_K_CALL : is_ldti ? FBC_K_LDTI :
                      is_halt ? FBC_K_HALT : FBC_K_STATUS_TEST;
            end else if (is_ret) begin
              // Restore then drop stack pointer
              pc <= address_stack_reg;
              rom_addr <= address_stack_reg;
              sp <= 1'b0;
            end else if (is_rdt) begin
              // Nibble read clears carry
              accum_out <= ir[5] ? timer_value[9:6] : timer_value[5:2];
              accum_we <= 1'b1;
              carry_flag <= 1'b0;
            end else if (is_wt1) begin
              timer_value[9:6] <= accum_in;
              timer_value[1] <= 1'b0;
            end else if (is_wt0) begin
              timer_value[5:2] <= accum_in;
              timer_value[0] <= 1'b0;
            end else if (is_ldtm) begin
              rom_addr <= {rom_page_control, rom_pointer_pair};
              ldtm_pend <= 1'b1;
            end else if (is_sttsr) begin
              // Register form of status test
              test_flag <= |(status_vec & low_bank_register);
              timer_status <= tmr_expire;
            end else if (is_carry_on_all_ones) begin
              carry_flag <= (accum_in == 4'hF);
            end
          end
          FBC_OPND: begin
            state <= FBC_FETCH;
            rom_addr <= pc_next1 & page_mask;
            pc <= pc_next1 & page_mask;
            unique case (kind)
              FBC_K_JF: if (test_flag) begin
                pc <= {opg, target};
                rom_addr <= {opg, target};
              end
              FBC_K_JNF: if (!test_flag) begin
                pc <= {opg, target};
                rom_addr <= {opg, target};
              end
              FBC_K_CALL: begin
                // Second cycle: save return, load target
                sp <= 1'b1;
                address_stack_reg <= pc_next1 & page_mask;
                pc <= {opg, target};
                rom_addr <= {opg, target};
              end
              FBC_K_LDTI: timer_value <= ir;
              FBC_K_HALT: begin
                standby <= 1'b1;
                standby_cond <= ir[3:0];
                state <= FBC_STBY;
              end
              FBC_K_STATUS_TEST: begin
                status_test_reg <= ir[3:0];
                test_flag <= |(status_vec & ir[3:0]);
                timer_status <= tmr_expire;
              end
              default: ;
            endcase
          end
          FBC_STBY: begin
            if (wk2 || |(status_vec & standby_cond)) begin
              standby <= 1'b0;
              state <= FBC_FETCH;
            end
          end
          default: state <= FBC_FETCH;
        endcase
      end
    end
  end

  a_ret_restores: assert property (@(posedge mclk) disable iff (!rst_n)
    state == FBC_FETCH && is_ret && sp && !ldtm_pend |=> pc == $past(address_stack_reg))
    else $error("return did not restore pc");
  a_carry_on_all_ones_carry: assert property (@(posedge mclk) disable iff (!rst_n)
    state == FBC_FETCH && is_carry_on_all_ones && !stack_fault && !ldtm_pend
    |=> carry_flag == ($past(accum_in) == 4'hF))
    else $error("carry wrong after all-ones test");
  a_ret_underflow: assert property (@(posedge mclk) disable iff (!rst_n)
    state == FBC_FETCH && is_ret && !sp && !ldtm_pend
    |=> internal_reset && pc == `FBC_RESET_PC)
    else $error("underflow did not reset");
  a_call_overflow: assert property (@(posedge mclk) disable iff (!rst_n)
    state == FBC_FETCH && is_call && sp && !ldtm_pend |=> internal_reset)
    else $error("overflow did not reset");
  a_rdt_carry: assert property (@(posedge mclk) disable iff (!rst_n)
    state == FBC_FETCH && is_rdt && !stack_fault && !ldtm_pend
    |=> accum_we && !carry_flag)
    else $error("timer read left carry");
  a_wt1_bit1: assert property (@(posedge mclk) disable iff (!rst_n)
    state == FBC_FETCH && is_wt1 && !ldtm_pend |=> !timer_value[1])
    else $error("bit 1 not cleared");
  a_halt_stby: assert property (@(posedge mclk) disable iff (!rst_n)
    state == FBC_OPND && kind == FBC_K_HALT && !ldtm_pend |=> standby)
    else $error("standby not entered");
  a_call_stack: assert property (@(posedge mclk) disable iff (!rst_n)
    state == FBC_OPND && kind == FBC_K_CALL && !ldtm_pend
    |=> sp && address_stack_reg == $past(pc_next1 & page_mask))
    else $error("call did not save pc");

  // Branch outcomes and page limit
  a_jf_taken: assert property (@(posedge mclk) disable iff (!rst_n)
    state == FBC_OPND && kind == FBC_K_JF && test_flag
    |=> pc[9:0] == $past(target))
    else $error("flag jump not taken");
  a_jnf_taken: assert property (@(posedge mclk) disable iff (!rst_n)
    state == FBC_OPND && kind == FBC_K_JNF && !test_flag
    |=> pc[9:0] == $past(target))
    else $error("flag-clear jump not taken");
  a_false_skip: assert property (@(posedge mclk) disable iff (!rst_n)
    state == FBC_OPND &&
    ((kind == FBC_K_JF && !test_flag) || (kind == FBC_K_JNF && test_flag))
    |=> pc == $past(pc_next1 & page_mask))
    else $error("false branch did not skip");
  a_page_small: assert property (@(posedge mclk) disable iff (!rst_n)
    !BIG_ROM |-> !pc[10])
    else $error("small variant left page 0");

  // Timer loads and expiry
  a_ldti_load: assert property (@(posedge mclk) disable iff (!rst_n)
    state == FBC_OPND && kind == FBC_K_LDTI |=> timer_value == $past(ir))
    else $error("immediate timer load wrong");
  a_wt0_bit0: assert property (@(posedge mclk) disable iff (!rst_n)
    state == FBC_FETCH && is_wt0 && !ldtm_pend && !stack_fault
    |=> !timer_value[0] && timer_value[5:2] == $past(accum_in))
    else $error("low nibble write wrong");
  a_ldtm_load: assert property (@(posedge mclk) disable iff (!rst_n)
    ldtm_pend |=> timer_value == $past(rom_data))
    else $error("table timer load wrong");
  a_tstat_set: assert property (@(posedge mclk) disable iff (!rst_n)
    tmr_expire |=> timer_status)
    else $error("timer expiry lost");

  // Status test, standby and internal reset
  a_sttsi_flag: assert property (@(posedge mclk) disable iff (!rst_n)
    state == FBC_OPND && kind == FBC_K_STATUS_TEST
    |=> test_flag == $past(|(status_vec & ir[3:0])))
    else $error("immediate status test wrong");
  a_stby_hold: assert property (@(posedge mclk) disable iff (!rst_n)
    state == FBC_STBY && !wk2 && !(|(status_vec & standby_cond))
    |=> standby)
    else $error("standby left without cause");
  a_ireset_pc: assert property (@(posedge mclk) disable iff (!rst_n)
    internal_reset |-> pc == `FBC_RESET_PC && !sp)
    else $error("internal reset left state");
endmodule

// >>> rtl/fbc_pkg.sv
// Types for the flag branch, call and timer execution block
package fbc_pkg;
  typedef enum logic [2:0] {
    FBC_FETCH = 3'b001,
    FBC_OPND = 3'b010,
    FBC_STBY = 3'b100
  } fbc_state_type;
  typedef enum logic [3:0] {
    FBC_K_NONE = 4'h0,
    FBC_K_JF = 4'h1,
    FBC_K_JNF = 4'h2,
    FBC_K_CALL = 4'h3,
    FBC_K_LDTI = 4'h4,
    FBC_K_HALT = 4'h5,
    FBC_K_STATUS_TEST = 4'h6
  } fbc_kind_type;
endpackage

// >>> verification/fbc_rom_model.sv
// Program memory model that feeds instruction words to the block
module fbc_rom_model (
  input wire logic [10:0] rom_addr,
  output logic [9:0] rom_data
);
  timeunit 1ns;
  timeprecision 1ns;
  // Two 1K pages, page bit on top
  logic [9:0] mem [0:2047];
  assign rom_data = mem[rom_addr];
endmodule

// >>> verification/test_flag_branch_call_timer_exec.sv
// Self-checking bench for the flag branch, call and timer block
`include "fbc_cfg.svh"
`define CHK(got, exp) begin \
  num_checks++; \
  if ((got) !== (exp)) begin \
    n_errors++; \
    $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp); \
  end \
end
module test_flag_branch_call_timer_exec;
  timeunit 1ns;
  timeprecision 1ns;
  logic mclk = 0, arst_n = 0, sa = 0, wake = 0;
  logic [9:0] rom_data, timer_value;
  logic [10:0] rom_addr;
  logic [3:0] accum_in = 0, accum_out, standby_cond, lbr = 0;
  logic [2:0] ppc = 0;
  logic [7:0] ppr = 0;
  logic accum_we, carry_flag, test_flag, timer_status;
  logic standby, internal_reset;
  int n_errors = 0, num_checks = 0;
  fbc_rom_model rom (.rom_addr(rom_addr), .rom_data(rom_data));
  fbc_exec #(.TMR_DIV(64), .BIG_ROM(1'b1)) uut (
    .mclk(mclk), .arst_n(arst_n), .rom_data(rom_data),
    .rom_addr(rom_addr), .accum_in(accum_in),
    .low_bank_register(lbr), .rom_page_control(ppc),
    .rom_pointer_pair(ppr), .sense_input_a(sa),
    .sense_input_b(1'b0), .key_io_lines(8'h00),
    .key_input_lines(4'h0), .wake(wake), .accum_out(accum_out),
    .accum_we(accum_we), .carry_flag(carry_flag),
    .test_flag(test_flag), .timer_value(timer_value),
    .timer_status(timer_status), .standby(standby),
    .standby_cond(standby_cond), .internal_reset(internal_reset)
  );
  always #50 mclk = ~mclk;
  // Operand word layout of a branch target
  function automatic logic [9:0] enc(input logic [9:0] a);
    return {a[9], a[7:4], a[8], a[3:0]};
  endfunction
  task automatic tick;
    @(posedge mclk);
    #10;
  endtask
  // Reset held, memory cleared; address 1..63 filled
  task automatic boot(input logic [9:0] fill);
    arst_n = 0;
    for (int i = 0; i < 2048; i++) begin
      rom.mem[i] = (i > 0 && i < 64) ? fill : 10'h000;
    end
    repeat (6) tick();
    arst_n = 1;
  endtask
  // Wait for fetch of a0, step n cycles, compare address
  task automatic at(input logic [10:0] a0, input int n,
                    input logic [10:0] exp);
    int k;
    k = 0;
    while (rom_addr !== a0 && k < 40) begin
      tick();
      k++;
    end
    repeat (n) tick();
    `CHK(rom_addr, exp)
  endtask
  task automatic wait_ireset;
    int k;
    k = 0;
    while (internal_reset !== 1'b1 && k < 6) begin
      tick();
      k++;
    end
    `CHK(internal_reset, 1'b1)
  endtask
  task automatic t_jf;
    sa = 1;
    boot(10'h000);
    rom.mem[1] = `FBC_OP_STTSI;
    rom.mem[2] = 10'h001;
    rom.mem[3] = `FBC_OP_JF_P0;
    rom.mem[4] = enc(10'h123);
    rom.mem[11'h123] = `FBC_OP_JNF_P0;
    rom.mem[11'h124] = enc(10'h040);
    rom.mem[11'h125] = `FBC_OP_STTSI;
    rom.mem[11'h127] = 10'h020;
    lbr = 4'h1;
    at(11'h003, 2, 11'h123);
    `CHK(test_flag, 1'b1)
    at(11'h123, 2, 11'h125);
    at(11'h125, 2, 11'h127);
    `CHK(test_flag, 1'b0)
    at(11'h127, 1, 11'h128);
    `CHK(test_flag, 1'b1)
    sa = 0;
    lbr = 4'h0;
  endtask
  task automatic t_jnf;
    boot(10'h000);
    rom.mem[1] = `FBC_OP_JNF_P0;
    rom.mem[2] = enc(10'h123);
    rom.mem[11'h123] = `FBC_OP_JF_P0;
    rom.mem[11'h124] = enc(10'h040);
    at(11'h001, 2, 11'h123);
    at(11'h123, 2, 11'h125);
    // Timer value 0 expires after 64 clocks
    repeat (57) tick();
    `CHK(timer_status, 1'b0)
    repeat (2) tick();
    `CHK(timer_status, 1'b1)
  endtask
  task automatic t_call(input logic twice);
    boot(10'h000);
    rom.mem[1] = `FBC_OP_CALL;
    rom.mem[2] = enc(10'h050);
    rom.mem[3] = `FBC_OP_RET;
    rom.mem[11'h050] = twice ? `FBC_OP_CALL : `FBC_OP_RET;
    rom.mem[11'h051] = enc(10'h060);
    at(11'h001, 2, 11'h050);
    if (!twice) begin
      at(11'h050, 1, 11'h003);
    end
    wait_ireset();
    at(11'h001, 0, 11'h001);
  endtask
  task automatic t_carry_on_all_ones;
    boot(`FBC_OP_CARRY_ON_ALL_ONES);
    at(11'h001, 0, 11'h001);
    for (int v = 0; v < 16; v++) begin
      accum_in = v[3:0];
      repeat (2) tick();
      `CHK(carry_flag, v == 15)
    end
  endtask
  task automatic t_timer;
    accum_in = 4'hF;
    boot(10'h000);
    rom.mem[1] = `FBC_OP_CARRY_ON_ALL_ONES;
    rom.mem[2] = `FBC_OP_LDTI;
    rom.mem[3] = 10'h2A5;
    rom.mem[4] = `FBC_OP_RDT1;
    rom.mem[5] = `FBC_OP_RDT0;
    rom.mem[6] = `FBC_OP_WRT1;
    rom.mem[7] = `FBC_OP_WRT0;
    rom.mem[8] = `FBC_OP_LDTM;
    rom.mem[11'h120] = 10'h155;
    ppc = 3'h1;
    ppr = 8'h20;
    at(11'h002, 2, 11'h004);
    `CHK(timer_value, 10'h2A5)
    `CHK(carry_flag, 1'b1)
    tick();
    `CHK(accum_we, 1'b1)
    `CHK(accum_out, 4'hA)
    tick();
    `CHK(accum_out, 4'h9)
    `CHK(carry_flag, 1'b0)
    tick();
    `CHK(timer_value, 10'h3E5)
    accum_in = 4'h0;
    tick();
    `CHK(timer_value, 10'h3C0)
    tick();
    `CHK(rom_addr, 11'h120)
    tick();
    `CHK(timer_value, 10'h155)
    `CHK(rom_addr, 11'h009)
    ppc = 3'h0;
    ppr = 8'h00;
  endtask
  task automatic t_halt;
    int k;
    boot(10'h000);
    rom.mem[1] = `FBC_OP_HALT;
    rom.mem[2] = 10'h005;
    at(11'h001, 3, 11'h003);
    `CHK(standby, 1'b1)
    `CHK(standby_cond, 4'h5)
    wake = 1;
    k = 0;
    while (standby !== 1'b0 && k < 8) begin
      tick();
      k++;
    end
    `CHK(standby, 1'b0)
    wake = 0;
  endtask
  task automatic wrap_up;
    if (n_errors == 0 && num_checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  initial begin
    #10;
    t_jf();
    t_jnf();
    t_call(1'b0);
    t_call(1'b1);
    t_carry_on_all_ones();
    t_timer();
    t_halt();
    wrap_up();
  end
  initial begin
    repeat (3000) @(posedge mclk);
    n_errors++;
    wrap_up();
  end
endmodule
